// File: src/uoc_overhead_crc.v
// overhead bit filtering, superframe check and block error counting
//
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "uoc_regs.vh"

module uoc_overhead_crc (
  // clock and reset
  input wire mclk,
  input wire rst_n,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`UOC_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // receive framer
  input wire rxSfStart,
  input wire rxSfEnd,
  input wire rxBfEnd,
  input wire [2:0] rxBfIdx,
  input wire rxM4Bit,
  input wire [2:0] rxSpare,
  input wire rxFebeBit,
  input wire [11:0] rxCrc,
  input wire rxDataValid,
  input wire rxDataBit,
  // transmit framer
  input wire txSfStart,
  input wire txDataValid,
  input wire txDataBit,
  input wire [7:0] smM4,
  output reg [7:0] txM4,
  output reg [2:0] txSpareOut,
  output reg txFebe,
  output reg [11:0] txCrc,
  // line scrambling
  input wire txLineValid,
  input wire txLineBit,
  output reg txScrBit,
  input wire rxLineValid,
  input wire rxLineBit,
  output reg rxDescrBit,
  // activation logic and maintenance commands
  input wire lineOperational,
  input wire nccCmd,
  input wire rccCmd,
  input wire rtnCmd,
  output reg smAct,
  output reg smDea,
  output reg smUoa,
  output reg smSai,
  output reg eventFlag
);

  reg [7:0] txMask_ff;
  reg [7:0] rxMask_ff;
  reg [7:0] txLatch_ff;
  reg [7:0] rxOverhead_ff;
  reg [3:0] txSpare_ff;
  reg [2:0] rxSpareVal_ff;
  reg [2:0] spareRaw_ff;
  reg spareRawOk_ff;
  reg [4:0] filter_ff;
  reg [2:0] options_ff;
  reg [7:0] nearCnt_ff;
  reg [7:0] farCnt_ff;
  reg [4:0] status_ff;
  reg [7:0] m4Chg_ff;
  reg [2:0] pendEvt_ff;
  reg [11:0] rxCrcAcc_ff;
  reg [11:0] txCrcAcc_ff;
  reg [11:0] savedCrc_ff;
  reg haveSaved_ff;
  reg nccAuto_ff;
  reg rccAuto_ff;
  reg febePend_ff;
  reg [`UOC_SCR_LEN-1:0] scr_ff;
  reg [`UOC_SCR_LEN-1:0] dscr_ff;
  reg [31:0] nxt_prdata;
  reg nxt_pslverr;
  wire [7:0] m4Val;
  wire [7:0] tllVal;
  wire [7:0] smSel;
  localparam [7:0] M4_RST = `UOC_RST_M4;

  function [11:0] crcStep;
    input [11:0] acc;
    input din;
    reg fb;
    begin
      fb = din ^ acc[11];
      crcStep = {acc[10:0], 1'b0} ^ (fb ? `UOC_CRC_POLY : 12'h000);
    end
  endfunction

  // apb decode
  wire apbDone = psel & penable & pready;
  wire wrEn = apbDone & pwrite;
  wire rdEn = apbDone & ~pwrite;
  wire rdNear = rdEn & (paddr == `UOC_OFF_NEARCNT);
  wire rdFar = rdEn & (paddr == `UOC_OFF_FARCNT);
  wire rdStatus = rdEn & (paddr == `UOC_OFF_STATUS);
  wire rdM4Chg = rdEn & (paddr == `UOC_OFF_M4CHG);
  wire transp = options_ff[`UOC_OPT_TRANSP];

  // check of the previous superframe arrives in the current one
  wire crcEval = rxSfEnd & haveSaved_ff;
  wire crcOk = (rxCrc == savedCrc_ff);
  wire mismatch = crcEval & ~crcOk;
  wire nearEvt = mismatch & ~nccAuto_ff;
  wire farEvt = rxSfEnd & (rxFebeBit == `UOC_FAR_BLOCK_ERROR_ERR) & ~rccAuto_ff;
  wire [1:0] m4Mode = filter_ff[`UOC_FLT_MODE];

  always @* begin
    nxt_prdata = 32'h0000_0000;
    nxt_pslverr = 1'b0;
    case (paddr)
      `UOC_OFF_TXMASK: nxt_prdata[7:0] = txMask_ff;
      `UOC_OFF_RXMASK: nxt_prdata[7:0] = rxMask_ff;
      `UOC_OFF_TXLATCH: nxt_prdata[7:0] = txLatch_ff;
      `UOC_OFF_RXVAL: nxt_prdata[7:0] = rxOverhead_ff;
      `UOC_OFF_TXSPARE: nxt_prdata[3:0] = txSpare_ff;
      `UOC_OFF_RXSPARE: nxt_prdata[2:0] = rxSpareVal_ff;
      `UOC_OFF_FILTER: nxt_prdata[4:0] = filter_ff;
      `UOC_OFF_OPTIONS: nxt_prdata[2:0] = options_ff;
      `UOC_OFF_NEARCNT: nxt_prdata[7:0] = nearCnt_ff;
      `UOC_OFF_FARCNT: nxt_prdata[7:0] = farCnt_ff;
      `UOC_OFF_STATUS: nxt_prdata[4:0] = status_ff;
      `UOC_OFF_M4CHG: nxt_prdata[7:0] = m4Chg_ff;
      default: nxt_pslverr = 1'b1;
    endcase
  end

  // data captured in the setup cycle, answered in the first access cycle
  always @(posedge mclk) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & nxt_pslverr;
      prdata <= (psel & ~penable & ~pwrite) ? nxt_prdata : 32'h0000_0000;
    end
  end

  // software registers
  always @(posedge mclk) begin
    if (!rst_n) begin
      txMask_ff <= `UOC_RST_TXMASK;
      rxMask_ff <= `UOC_RST_RXMASK;
      txLatch_ff <= `UOC_RST_TXLATCH;
      txSpare_ff <= `UOC_RST_TXSPARE;
      filter_ff <= `UOC_RST_FILTER;
      options_ff <= `UOC_RST_OPTIONS;
    end else if (wrEn) begin
      case (paddr)
        `UOC_OFF_TXMASK: txMask_ff <= pwdata[7:0];
        `UOC_OFF_RXMASK: rxMask_ff <= pwdata[7:0];
        `UOC_OFF_TXLATCH: txLatch_ff <= pwdata[7:0];
        `UOC_OFF_TXSPARE: txSpare_ff <= pwdata[3:0];
        `UOC_OFF_FILTER: filter_ff <= pwdata[4:0];
        `UOC_OFF_OPTIONS: options_ff <= pwdata[2:0];
        default: ;
      endcase
    end
  end

  // maintenance commands; a new command beats a cancel in the same cycle
  always @(posedge mclk) begin
    if (!rst_n) begin
      nccAuto_ff <= 1'b0;
      rccAuto_ff <= 1'b0;
    end else begin
      nccAuto_ff <= (nccCmd & ~transp) | (nccAuto_ff & ~rtnCmd);
      rccAuto_ff <= (rccCmd & ~transp) | (rccAuto_ff & ~rtnCmd);
    end
  end

  // receive check
  always @(posedge mclk) begin
    if (!rst_n) begin
      rxCrcAcc_ff <= 12'h000;
      savedCrc_ff <= 12'h000;
      haveSaved_ff <= 1'b0;
    end else begin
      if (rxSfStart)
        rxCrcAcc_ff <= rxDataValid ? crcStep(12'h000, rxDataBit) : 12'h000;
      else if (rxDataValid)
        rxCrcAcc_ff <= crcStep(rxCrcAcc_ff, rxDataBit);
      if (rxSfEnd) begin
        savedCrc_ff <= rxCrcAcc_ff;
        haveSaved_ff <= lineOperational;
      end
    end
  end

  // transmit check, M4, spare and far-end bits latched per superframe
  always @(posedge mclk) begin
    if (!rst_n) begin
      txCrcAcc_ff <= 12'h000;
      txCrc <= 12'h000;
      txM4 <= `UOC_RST_TXLATCH;
      txSpareOut <= `UOC_RST_TXSPARE_OUT;
      txFebe <= ~`UOC_FAR_BLOCK_ERROR_ERR;
      febePend_ff <= 1'b0;
    end else begin
      if (txSfStart) begin
        txCrcAcc_ff <= txDataValid ? crcStep(12'h000, txDataBit) : 12'h000;
        txCrc <= txCrcAcc_ff ^ {12{rccAuto_ff | options_ff[`UOC_OPT_CORRUPT_CHECKSUM_CTL]}};
        txM4 <= (txMask_ff & smM4) | (~txMask_ff & txLatch_ff);
        txSpareOut <= txSpare_ff[2:0];
        txFebe <= options_ff[`UOC_OPT_FEBESW] ? txSpare_ff[`UOC_SPARE_FAR_BLOCK_ERROR] :
                  (febePend_ff ? `UOC_FAR_BLOCK_ERROR_ERR : ~`UOC_FAR_BLOCK_ERROR_ERR);
      end else if (txDataValid)
        txCrcAcc_ff <= crcStep(txCrcAcc_ff, txDataBit);
      febePend_ff <= mismatch | (febePend_ff & ~txSfStart);
    end
  end

  // per-bit M4 filters
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : gFilt
      reg raw_ff;
      reg rawPrev_ff;
      reg tllCand_ff;
      reg [1:0] tllCnt_ff;
      reg tllVal_ff;
      reg ctCand_ff;
      reg [1:0] ctCnt_ff;
      reg val_ff;
      wire hit = rxBfEnd & (rxBfIdx == i);
      wire rawNow = hit ? rxM4Bit : raw_ff;
      wire tllHit = hit & (rxM4Bit == tllCand_ff) & (tllCnt_ff == `UOC_TLL_HIT);
      wire ctHit = crcEval & crcOk & (rawPrev_ff == ctCand_ff) &
                   (ctCnt_ff == `UOC_TLL_HIT);
      assign m4Val[i] = val_ff;
      assign tllVal[i] = tllVal_ff;
      always @(posedge mclk) begin
        if (!rst_n || !lineOperational) begin
          raw_ff <= M4_RST[i];
          rawPrev_ff <= M4_RST[i];
          tllCand_ff <= M4_RST[i];
          tllCnt_ff <= 2'h0;
          tllVal_ff <= M4_RST[i];
          ctCand_ff <= M4_RST[i];
          ctCnt_ff <= 2'h0;
          val_ff <= M4_RST[i];
        end else begin
          raw_ff <= rawNow;
          if (rxSfEnd)
            rawPrev_ff <= rawNow;
          if (hit) begin
            tllCand_ff <= rxM4Bit;
            if (rxM4Bit != tllCand_ff)
              tllCnt_ff <= 2'h1;
            else if (tllCnt_ff != `UOC_TLL_HIT)
              tllCnt_ff <= tllCnt_ff + 2'h1;
          end
          if (tllHit)
            tllVal_ff <= rxM4Bit;
          if (crcEval) begin
            ctCand_ff <= rawPrev_ff;
            if (!crcOk || rawPrev_ff != ctCand_ff)
              ctCnt_ff <= {1'b0, crcOk};
            else if (ctCnt_ff != `UOC_TLL_HIT)
              ctCnt_ff <= ctCnt_ff + 2'h1;
          end
          case (m4Mode)
            `UOC_MODE_CHANGE: if (hit) val_ff <= rxM4Bit;
            `UOC_MODE_TLL: if (tllHit) val_ff <= rxM4Bit;
            `UOC_MODE_CRC: if (crcEval && crcOk) val_ff <= rawPrev_ff;
            `UOC_MODE_CRCTLL: if (ctHit) val_ff <= rawPrev_ff;
            default: val_ff <= val_ff;
          endcase
        end
      end
    end
  endgenerate

  // activation logic sees approvals one clock after the filter takes them
  assign smSel = filter_ff[`UOC_FLT_SAME] ? m4Val : tllVal;
  always @(posedge mclk) begin
    if (!rst_n || !lineOperational) begin
      smAct <= 1'b0;
      smDea <= 1'b1;
      smUoa <= 1'b0;
      smSai <= 1'b0;
    end else begin
      smAct <= smSel[`UOC_M4_ACT];
      smDea <= smSel[`UOC_M4_DEA];
      smUoa <= txMask_ff[`UOC_M4_SAI] ? smSel[`UOC_M4_UOA] : 1'b1;
      smSai <= smSel[`UOC_M4_SAI];
    end
  end

  // spare bits: default waits for a clean check of the same superframe
  wire [1:0] spMode = filter_ff[`UOC_FLT_SPARE];
  wire spOnChange = (spMode == `UOC_SPARE_CHANGE) ||
                    (spMode == `UOC_SPARE_SAME && m4Mode == `UOC_MODE_CHANGE);
  wire [2:0] spareNext = spOnChange ? rxSpare : spareRaw_ff;
  wire spareTake = rxSfEnd & (spOnChange | (spareRawOk_ff & crcOk));
  wire [7:0] m4Changes = (m4Val ^ rxOverhead_ff) & rxMask_ff;
  wire spareChg = spareTake & (spareNext != rxSpareVal_ff);

  // receive reports, posted once a whole superframe is in
  always @(posedge mclk) begin
    if (!rst_n) begin
      rxOverhead_ff <= `UOC_RST_M4;
      rxSpareVal_ff <= `UOC_RST_RXSPARE;
      spareRaw_ff <= `UOC_RST_RXSPARE;
      spareRawOk_ff <= 1'b0;
      m4Chg_ff <= 8'h00;
    end else begin
      if (rxSfEnd) begin
        rxOverhead_ff <= m4Val;
        spareRaw_ff <= rxSpare;
        spareRawOk_ff <= haveSaved_ff | lineOperational;
      end
      if (spareTake)
        rxSpareVal_ff <= spareNext;
      // read data is taken at setup, so only the bits shown are cleared
      m4Chg_ff <= (rxSfEnd ? m4Changes : 8'h00) |
                  (rdM4Chg ? (m4Chg_ff & ~prdata[7:0]) : m4Chg_ff);
    end
  end

  // error events wait for the next superframe start, then become flags
  wire [4:0] newStatus;
  assign newStatus[`UOC_ST_NEAR] = rxSfStart & pendEvt_ff[0];
  assign newStatus[`UOC_ST_FAR] = rxSfStart & pendEvt_ff[1];
  assign newStatus[`UOC_ST_BOTH] = rxSfStart & pendEvt_ff[2];
  assign newStatus[`UOC_ST_M4] = rxSfEnd & (|m4Changes);
  assign newStatus[`UOC_ST_SPARE] = spareChg;
  // a flag set between setup and access is not lost by the read
  wire [4:0] statusKeep = rdStatus ? (status_ff & ~prdata[4:0]) : status_ff;

  always @(posedge mclk) begin
    if (!rst_n) begin
      pendEvt_ff <= 3'h0;
      status_ff <= 5'h00;
      eventFlag <= 1'b0;
    end else begin
      if (rxSfEnd)
        pendEvt_ff <= {nearEvt & farEvt, farEvt, nearEvt};
      else if (rxSfStart)
        pendEvt_ff <= 3'h0;
      status_ff <= newStatus | statusKeep;
      eventFlag <= |(newStatus | statusKeep);
    end
  end

  // block error counters
  always @(posedge mclk) begin
    if (!rst_n || !lineOperational) begin
      nearCnt_ff <= 8'h00;
      farCnt_ff <= 8'h00;
    end else begin
      // only the count returned at setup is cleared
      if (rdNear)
        nearCnt_ff <= nearCnt_ff - prdata[7:0] + {7'h00, nearEvt};
      else if (nearEvt && nearCnt_ff != `UOC_CNT_MAX)
        nearCnt_ff <= nearCnt_ff + 8'h01;
      if (rdFar)
        farCnt_ff <= farCnt_ff - prdata[7:0] + {7'h00, farEvt};
      else if (farEvt && farCnt_ff != `UOC_CNT_MAX)
        farCnt_ff <= farCnt_ff + 8'h01;
    end
  end

  // self-synchronising scrambler and descrambler, not programmable
  wire scrOut = txLineBit ^ scr_ff[`UOC_SCR_TAP_A] ^ scr_ff[`UOC_SCR_TAP_B];
  wire dscrOut = rxLineBit ^ dscr_ff[`UOC_SCR_TAP_A] ^
                 dscr_ff[`UOC_SCR_TAP_B];
  always @(posedge mclk) begin
    if (!rst_n) begin
      scr_ff <= {`UOC_SCR_LEN{1'b0}};
      dscr_ff <= {`UOC_SCR_LEN{1'b0}};
      txScrBit <= 1'b0;
      rxDescrBit <= 1'b0;
    end else begin
      if (txLineValid) begin
        scr_ff <= {scr_ff[`UOC_SCR_LEN-2:0], scrOut};
        txScrBit <= scrOut;
      end
      if (rxLineValid) begin
        dscr_ff <= {dscr_ff[`UOC_SCR_LEN-2:0], rxLineBit};
        rxDescrBit <= dscrOut;
      end
    end
  end

endmodule

// File: src/uoc_regs.vh
// register map, field positions, reset values and constants of the block
`ifndef UOC_REGS_VH
`define UOC_REGS_VH

// register byte offsets
`define UOC_ADDR_W 8
`define UOC_OFF_TXMASK 8'h00
`define UOC_OFF_RXMASK 8'h04
`define UOC_OFF_TXLATCH 8'h08
`define UOC_OFF_RXVAL 8'h0C
`define UOC_OFF_TXSPARE 8'h10
`define UOC_OFF_RXSPARE 8'h14
`define UOC_OFF_FILTER 8'h18
`define UOC_OFF_OPTIONS 8'h1C
`define UOC_OFF_NEARCNT 8'h20
`define UOC_OFF_FARCNT 8'h24
`define UOC_OFF_STATUS 8'h28
`define UOC_OFF_M4CHG 8'h2C

// reset values
`define UOC_RST_TXMASK 8'hFF
`define UOC_RST_RXMASK 8'h00
`define UOC_RST_TXLATCH 8'hFF
`define UOC_RST_M4 8'h02
`define UOC_RST_TXSPARE 4'hF
`define UOC_RST_TXSPARE_OUT 3'h7
`define UOC_RST_RXSPARE 3'h7
`define UOC_RST_FILTER 5'h00
`define UOC_RST_OPTIONS 3'h0

// M4 bit positions
`define UOC_M4_ACT 0
`define UOC_M4_DEA 1
`define UOC_M4_UOA 2
`define UOC_M4_SAI 6

// filter select fields
`define UOC_FLT_MODE 1:0
`define UOC_FLT_SAME 2
`define UOC_FLT_SPARE 4:3
`define UOC_MODE_CHANGE 2'h0
`define UOC_MODE_TLL 2'h1
`define UOC_MODE_CRC 2'h2
`define UOC_MODE_CRCTLL 2'h3
`define UOC_SPARE_CRC 2'h0
`define UOC_SPARE_SAME 2'h1
`define UOC_SPARE_CHANGE 2'h2

// option and spare fields
`define UOC_OPT_FEBESW 0
`define UOC_OPT_TRANSP 1
`define UOC_OPT_CORRUPT_CHECKSUM_CTL 2
`define UOC_SPARE_FAR_BLOCK_ERROR 3

// status bits
`define UOC_ST_NEAR 0
`define UOC_ST_FAR 1
`define UOC_ST_BOTH 2
`define UOC_ST_M4 3
`define UOC_ST_SPARE 4

// check, counters, filters, scrambler
`define UOC_CRC_POLY 12'h80F
`define UOC_CNT_MAX 8'hFF
`define UOC_TLL_HIT 2'h2
`define UOC_FAR_BLOCK_ERROR_ERR 1'b0
`define UOC_SCR_LEN 23
`define UOC_SCR_TAP_A 17
`define UOC_SCR_TAP_B 22

`endif

// File: verif/uoc_checker_properties.sv
// port-level checks of the overhead and check block
`timescale 1ns/1ps
module uoc_checker (
  // clock and reset
  input wire mclk,
  input wire rst_n,
  // apb
  input wire psel,
  input wire penable,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // framing
  input wire rxSfStart,
  input wire rxSfEnd,
  input wire rxBfEnd,
  input wire txSfStart,
  input wire [7:0] txM4,
  input wire [11:0] txCrc,
  // line and activation side
  input wire txLineValid,
  input wire txScrBit,
  input wire rxLineValid,
  input wire rxDescrBit,
  input wire lineOperational,
  input wire smAct,
  input wire smDea,
  input wire eventFlag
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  pready_setup_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  pready_only_a: assert property (pready |-> $past(psel) && !$past(penable))
    else $error("ready without setup");
  slverr_ready_a: assert property (pslverr |-> pready)
    else $error("slave error without ready");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data outside access");
  tx_hold_a: assert property (!txSfStart |=> $stable(txM4) && $stable(txCrc))
    else $error("transmit overhead moved between superframes");
  sm_idle_a: assert property (!lineOperational |=> !smAct && smDea)
    else $error("activation bits not at idle values");
  dea_cause_a: assert property ($changed(smDea) |-> $past(rxBfEnd) ||
    $past(rxBfEnd, 2) || $past(rxSfEnd) || $past(rxSfEnd, 2) ||
    !$past(lineOperational) || !$past(lineOperational, 2))
    else $error("activation bit changed without approval");
  event_cause_a: assert property ($rose(eventFlag) |->
    $past(rxSfStart) || $past(rxSfEnd))
    else $error("event outside superframe boundary");
  scr_hold_a: assert property (!txLineValid |=> $stable(txScrBit))
    else $error("scrambler moved without data");
  dscr_hold_a: assert property (!rxLineValid |=> $stable(rxDescrBit))
    else $error("descrambler moved without data");

  cover property (pslverr);
  cover property ($rose(eventFlag));
  cover property (txSfStart ##1 txCrc != 12'h000);
endmodule

bind uoc_overhead_crc uoc_checker chk_u (.mclk(mclk), .rst_n(rst_n),
  .psel(psel), .penable(penable), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .rxSfStart(rxSfStart), .rxSfEnd(rxSfEnd),
  .rxBfEnd(rxBfEnd), .txSfStart(txSfStart), .txM4(txM4), .txCrc(txCrc),
  .txLineValid(txLineValid), .txScrBit(txScrBit),
  .rxLineValid(rxLineValid), .rxDescrBit(rxDescrBit),
  .lineOperational(lineOperational), .smAct(smAct), .smDea(smDea),
  .eventFlag(eventFlag));

// File: verif/uoc_lt_model.sv
// far-end line termination model driving receive superframes
`timescale 1ns/1ps
module uoc_lt_model (
  // clock
  input wire logic mclk,
  // receive framer side
  output logic rxSfStart,
  output logic rxSfEnd,
  output logic rxBfEnd,
  output logic [2:0] rxBfIdx,
  output logic rxM4Bit,
  output logic [2:0] rxSpare,
  output logic rxFebeBit,
  output logic [11:0] rxCrc,
  output logic rxDataValid,
  output logic rxDataBit
);
  logic [11:0] accCrc = 12'h000;
  logic [11:0] prevCrc = 12'h000;
  initial begin
    {rxSfStart, rxSfEnd, rxBfEnd, rxM4Bit, rxDataValid, rxDataBit} = 6'h00;
    {rxBfIdx, rxSpare, rxFebeBit, rxCrc} = 19'h0_0000;
  end
  // one superframe: 8 basic frames of two data bits and the M4 bit
  task automatic send_sf(input logic [7:0] m4, input logic bad,
                         input logic far_block_error, input logic [2:0] spare);
    logic b;
    @(posedge mclk);
    rxSfStart <= 1;
    accCrc = 12'h000;
    @(posedge mclk);
    rxSfStart <= 0;
    for (int i = 0; i < 8; i++) begin
      for (int j = 0; j < 3; j++) begin
        b = (j == 2) ? m4[i] : ((i + j) % 3 == 0);
        rxDataValid <= 1;
        rxDataBit <= b;
        accCrc = {accCrc[10:0], 1'b0} ^ ((accCrc[11] ^ b) ? 12'h80F : 12'h000);
        @(posedge mclk);
      end
      rxDataValid <= 0;
      rxDataBit <= ~b;
      rxBfEnd <= 1;
      rxBfIdx <= i[2:0];
      rxM4Bit <= m4[i];
      @(posedge mclk);
      rxBfEnd <= 0;
      rxM4Bit <= ~m4[i];
    end
    // check of the previous superframe travels in this one
    rxSfEnd <= 1;
    rxSpare <= spare;
    rxFebeBit <= far_block_error;
    rxCrc <= bad ? ~prevCrc : prevCrc;
    @(posedge mclk);
    rxSfEnd <= 0;
    prevCrc = accCrc;
    rxCrc <= ~rxCrc;
    rxFebeBit <= ~far_block_error;
    rxSpare <= ~spare;
  endtask
endmodule

// File: verif/uoc_overhead_crc_test.sv
// self-checking bench for overhead bits, check and error counters
`timescale 1ns/1ps
module uoc_overhead_crc_test;
  logic mclk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00, smM4 = 8'h3C, txM4;
  logic [31:0] pwdata = 32'h0000_0000, prdata, q;
  logic pready, pslverr, e, txFebe, smAct, smDea, smUoa, smSai, eventFlag;
  logic rxSfStart, rxSfEnd, rxBfEnd, rxM4Bit, rxFebeBit, rxDataValid, rxDataBit;
  logic [2:0] rxBfIdx, rxSpare, txSpareOut;
  logic [11:0] rxCrc, txCrc, crcX = 12'h000, crcP;
  logic txSfStart = 0, txDataValid = 0, txDataBit = 0, txLineValid = 0;
  logic txLineBit = 0, txScrBit, rxLineValid = 0, rxLineBit = 0, rxDescrBit;
  logic lineOperational = 0, nccCmd = 0, rccCmd = 0, rtnCmd = 0;
  int errTotal = 0, nTests = 0, ones;
  always #12.5 mclk = ~mclk;

  uoc_overhead_crc dut_u (.mclk(mclk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxSfStart(rxSfStart), .rxSfEnd(rxSfEnd), .rxBfEnd(rxBfEnd),
    .rxBfIdx(rxBfIdx), .rxM4Bit(rxM4Bit), .rxSpare(rxSpare),
    .rxFebeBit(rxFebeBit), .rxCrc(rxCrc), .rxDataValid(rxDataValid),
    .rxDataBit(rxDataBit), .txSfStart(txSfStart), .txDataValid(txDataValid),
    .txDataBit(txDataBit), .smM4(smM4), .txM4(txM4),
    .txSpareOut(txSpareOut), .txFebe(txFebe), .txCrc(txCrc),
    .txLineValid(txLineValid), .txLineBit(txLineBit), .txScrBit(txScrBit),
    .rxLineValid(rxLineValid), .rxLineBit(rxLineBit),
    .rxDescrBit(rxDescrBit), .lineOperational(lineOperational),
    .nccCmd(nccCmd), .rccCmd(rccCmd), .rtnCmd(rtnCmd), .smAct(smAct),
    .smDea(smDea), .smUoa(smUoa), .smSai(smSai), .eventFlag(eventFlag));

  uoc_lt_model lt_u (.mclk(mclk), .rxSfStart(rxSfStart), .rxSfEnd(rxSfEnd),
    .rxBfEnd(rxBfEnd), .rxBfIdx(rxBfIdx), .rxM4Bit(rxM4Bit),
    .rxSpare(rxSpare), .rxFebeBit(rxFebeBit), .rxCrc(rxCrc),
    .rxDataValid(rxDataValid), .rxDataBit(rxDataBit));

  task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    nTests++;
    if (g !== x) begin
      errTotal++;
      $display("Error %s expected %h seen %h", nm, x, g);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) errTotal++;
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task rd(input string nm, input logic [7:0] a, input logic [31:0] x);
    apb(0, a, 32'h0000_0000);
    chk(nm, x, q);
  endtask
  task cmd(input logic [2:0] k);
    @(posedge mclk);
    {nccCmd, rccCmd, rtnCmd} <= k;
    @(posedge mclk);
    {nccCmd, rccCmd, rtnCmd} <= 3'b000;
  endtask
  // outputs latched by this start carry the check of the previous data
  task tx_sf(input logic [15:0] bits);
    @(posedge mclk);
    txSfStart <= 1;
    @(posedge mclk);
    txSfStart <= 0;
    crcP = crcX;
    crcX = 12'h000;
    for (int i = 15; i >= 0; i--) begin
      txDataValid <= 1;
      txDataBit <= bits[i];
      crcX = {crcX[10:0], 1'b0} ^ ((crcX[11] ^ bits[i]) ? 12'h80F : 12'h000);
      @(posedge mclk);
    end
    txDataValid <= 0;
    txDataBit <= ~bits[0];
  endtask
  task finish_test;
    $display("comparisons %0d mismatches %0d", nTests, errTotal);
    if (errTotal == 0 && nTests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge mclk);
    errTotal++;
    finish_test;
  end

  initial begin
    repeat (12) @(posedge mclk);
    rst_n <= 1;
    rd("txmask", 8'h00, 32'h0000_00FF);
    rd("rxmask", 8'h04, 32'h0000_0000);
    rd("txlatch", 8'h08, 32'h0000_00FF);
    rd("txspare", 8'h10, 32'h0000_000F);
    rd("unmapped", 8'h30, 32'h0000_0000);
    chk("slverr", 1, e);
    chk("txspare out", 3'h7, txSpareOut);
    chk("sm dea", 1, smDea);
    // latch drives upper M4 bits, software spares and far-end bit
    wr_all();
    tx_sf(16'hB00C);
    tx_sf(16'h1234);
    chk("tx m4", 8'hAC, txM4);
    chk("tx crc", crcP, txCrc);
    chk("tx spare", 3'h2, txSpareOut);
    chk("tx far_block_error sw", 0, txFebe);
    apb(1, 8'h1C, 32'h0000_0000);
    lineOperational <= 1;
    apb(1, 8'h04, 32'h0000_00FF);
    repeat (4) lt_u.send_sf(8'h41, 0, 1, 3'h5);
    rd("rx m4", 8'h0C, 32'h0000_0041);
    rd("rx spare", 8'h14, 32'h0000_0005);
    chk("sm act", 1, smAct);
    chk("uoa forced", 1, smUoa);
    apb(1, 8'h00, 32'h0000_004F);
    lt_u.send_sf(8'h41, 0, 1, 3'h5);
    chk("uoa rx", 0, smUoa);
    // near and far error in the same superframe
    apb(0, 8'h28, 32'h0000_0000);
    lt_u.send_sf(8'h41, 1, 0, 3'h5);
    tx_sf(16'h0000);
    chk("tx far_block_error", 0, txFebe);
    lt_u.send_sf(8'h41, 0, 1, 3'h5);
    apb(0, 8'h28, 32'h0000_0000);
    chk("status", 32'h0000_0007, q & 32'h0000_0007);
    rd("near cnt", 8'h20, 1);
    rd("far cnt", 8'h24, 1);
    rd("near clr", 8'h20, 0);
    // automatic mode test commands, then cancel
    cmd(3'b110);
    lt_u.send_sf(8'h41, 1, 0, 3'h5);
    tx_sf(16'h5A5A);
    tx_sf(16'h0F0F);
    chk("crc inverted", crcP ^ 12'hFFF, txCrc);
    rd("near off", 8'h20, 0);
    rd("far off", 8'h24, 0);
    cmd(3'b001);
    lt_u.send_sf(8'h41, 1, 1, 3'h5);
    tx_sf(16'h0000);
    chk("crc normal", crcP, txCrc);
    rd("near on", 8'h20, 1);
    // transparent mode: detection stays, software corrupts the check
    apb(1, 8'h1C, 32'h0000_0006);
    cmd(3'b100);
    lt_u.send_sf(8'h41, 1, 1, 3'h5);
    tx_sf(16'h0000);
    chk("crc sw", crcP ^ 12'hFFF, txCrc);
    rd("near transp", 8'h20, 1);
    apb(1, 8'h1C, 32'h0000_0000);
    cmd(3'b001);
    repeat (258) lt_u.send_sf(8'h41, 1, 1, 3'h5);
    rd("near sat", 8'h20, 255);
    // check-covered filter shared with the activation path
    apb(1, 8'h18, 32'h0000_0006);
    lt_u.send_sf(8'h40, 0, 1, 3'h5);
    chk("sm act crc", 1, smAct);
    repeat (2) lt_u.send_sf(8'h40, 0, 1, 3'h5);
    chk("sm act late", 0, smAct);
    rd("rx m4 crc", 8'h0C, 32'h0000_0040);
    lt_u.send_sf(8'h41, 1, 1, 3'h5);
    lineOperational <= 0;
    repeat (3) @(posedge mclk);
    rd("near idle", 8'h20, 0);
    chk("sm act idle", 0, smAct);
    // constant ones looped through scrambler and descrambler
    ones = 0;
    for (int i = 0; i < 80; i++) begin
      @(posedge mclk);
      {txLineValid, txLineBit, rxLineValid} <= 3'b111;
      rxLineBit <= txScrBit;
      ones += int'(txScrBit === 1'b1);
      if (i > 60) chk("descrambled", 1, rxDescrBit);
    end
    chk("scrambled mix", 1, ones > 0 && ones < 80);
    finish_test;
  end

  task wr_all;
    apb(1, 8'h00, 32'h0000_000F);
    apb(1, 8'h08, 32'h0000_00A5);
    apb(1, 8'h10, 32'h0000_0002);
    apb(1, 8'h1C, 32'h0000_0001);
  endtask
endmodule
